/* File: logic/spm_pkg.sv */
// Purpose: Shared constants and types for the SPI master/slave port.
// Assumes: One 20 MHz system clock; serial pins already synchronous.
// Notes: Mode codes follow the port's 4-bit mode field.
package spm_pkg;
  localparam int CLK_HZ = 20000000;
  // Master bit rate dividers of the system clock
  localparam int DIV_FAST = 4;
  localparam int DIV_MID = 16;
  localparam int DIV_SLOW = 64;
  localparam logic [5:0] HALF_FAST = 6'(DIV_FAST / 2);
  localparam logic [5:0] HALF_MID = 6'(DIV_MID / 2);
  localparam logic [5:0] HALF_SLOW = 6'(DIV_SLOW / 2);
  localparam logic [5:0] CNT_ZERO = 6'h00;

  localparam logic [3:0] MODE_DIV4 = 4'h0;
  localparam logic [3:0] MODE_DIV16 = 4'h1;
  localparam logic [3:0] MODE_DIV64 = 4'h2;
  localparam logic [3:0] MODE_TMR2 = 4'h3;
  localparam logic [3:0] MODE_SLV_SS = 4'h4;
  localparam logic [3:0] MODE_SLV = 4'h5;

  // Half-period edges of one byte: 16 clock edges, plus a late sample slot
  localparam logic [4:0] EDGE_ZERO = 5'h00;
  localparam logic [4:0] EDGE_LAST = 5'h0F;
  localparam logic [4:0] EDGE_LATE = 5'h10;
  localparam logic [3:0] BITS_ZERO = 4'h0;
  localparam logic [3:0] BITS_LAST = 4'h7;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic {ST_IDLE, ST_SHIFT} spm_state_t;
endpackage

/* File: logic/spm_rate_if.sv */
// Purpose: Carries rate select, run and tick between port and rate generator.
// Assumes: Single clock domain.
// Notes: tick is a one-cycle pulse per serial half period.
`timescale 1ns/1ps
interface spm_rate_if;
  logic run;
  logic [1:0] sel;
  logic tmr2;
  logic tick;
  modport ctrl (output run, output sel, output tmr2, input tick);
  modport gen (input run, input sel, input tmr2, output tick);
endinterface

/* File: logic/spm_rate_gen.sv */
// Purpose: Half-period tick generator for master serial clock.
// Assumes: sel 0..2 divide the system clock, sel 3 follows timer match pulses.
// Notes: Counter clears while run is low, so a stalled transfer resumes cleanly.
`timescale 1ns/1ps
module spm_rate_gen
  import spm_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic SYS_RST_IN,
  spm_rate_if.gen rif
);
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic [5:0] half;

  always_comb
  begin
    case (rif.sel)
      2'h0: half = HALF_FAST;
      2'h1: half = HALF_MID;
      default: half = HALF_SLOW;
    endcase
    if (rif.sel == 2'h3)
    begin
      rif.tick = rif.run & rif.tmr2;
    end
    else
    begin
      rif.tick = rif.run & (cnt_q == 6'(half - 6'h01));
    end
    cnt_d = (!rif.run || rif.tick) ? CNT_ZERO : 6'(cnt_q + 6'h01);
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (SYS_RST_IN)
      cnt_q <= CNT_ZERO;
    else
      cnt_q <= cnt_d;
  end

  property p_fast_spacing;
    @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      (rif.tick && rif.sel == 2'h0) ##1 (rif.run && rif.sel == 2'h0) |-> !rif.tick ##1
      (!rif.run || rif.sel != 2'h0 || rif.tick);
  endproperty
  a_fast_spacing: assert property (p_fast_spacing)
    else $error("fast rate tick spacing is not two clocks");
endmodule

/* File: logic/spm_port.sv */
// Purpose: SPI port, master or slave, byte wide, MSB first, double-buffered receive.
// Assumes: Serial pins and control bits are synchronous to CLOCK_IN.
// Notes: Pin enables are registered, so pins follow controls one clock later.
`timescale 1ns/1ps
// Contract
// - Eight bits received: buffer, full flag, irq
// - One shift register, MSB first, via buffer
// - Write while busy dropped, collision flag sticky
// - Buffer read clears full flag
// - Master starts shifting on buffer write
// - Master with output off keeps receiving
// - Polarity sets idle clock, edge bit picks
// - Master rate: clk/4, /16, /64, timer/2
// - Edge bit set: data valid before edge
// - Sample phase: middle or end of bit
// - Slave shifts on external clock, flags byte
// - Select mode: active only while select low
// - Select high releases data output at once; here one clock later, as pin enables are registered
// - Select high or disable zeroes counter
// - Master freezes during sleep, then resumes
// - Slave shifts in sleep, wakes on byte
// - Reset disables port, aborts transfer
// - Bus modes map to polarity/edge pairs
module spm_port
  import spm_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic SYS_RST_IN,
  input wire logic PORT_ENABLE_IN,
  input wire logic [3:0] MODE_IN,
  input wire logic CLOCK_POLARITY_IN,
  input wire logic CLOCK_EDGE_IN,
  input wire logic SAMPLE_PHASE_IN,
  input wire logic SDO_DRIVE_EN_IN,
  input wire logic BUF_WR_IN,
  input wire logic [7:0] BUF_WDATA_IN,
  input wire logic BUF_RD_IN,
  input wire logic WRITE_COLLISION_FLAG_CLR_IN,
  input wire logic IRQ_CLR_IN,
  input wire logic IRQ_ENABLE_IN,
  input wire logic SLEEP_IN,
  input wire logic TMR2_MATCH_IN,
  input wire logic SCK_IN,
  input wire logic SDI_IN,
  input wire logic SS_N_IN,
  output logic [7:0] BUF_RDATA_OUT,
  output logic BUFFER_FULL_OUT,
  output logic PORT_IRQ_OUT,
  output logic WRITE_COLLISION_OUT,
  output logic BUSY_OUT,
  output logic WAKE_OUT,
  output logic SCK_OUT,
  output logic SCK_OE_OUT,
  output logic SDO_OUT,
  output logic SDO_OE_OUT
);
  spm_state_t state_q, state_d;
  logic [4:0] edge_q, edge_d;
  logic [3:0] bits_q, bits_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] buf_q, buf_d;
  logic bf_q, bf_d, irq_q, irq_d, write_collision_flag_q, write_collision_flag_d;
  logic sck_q, sck_d, sck_oe_q, sck_oe_d, sdo_q, sdo_d, sdo_oe_q, sdo_oe_d;
  logic sck_prev_q, wake_q, wake_d;
  logic master, slave, ss_block, serial_rst, busy;
  logic m_edge, s_edge, ev, change, sample, late_smp, rx_done, last_edge;
  logic [4:0] last_k;
  logic [7:0] rx_next;

  spm_rate_if rif ();

  spm_rate_gen u_rate (
    .CLOCK_IN(CLOCK_IN),
    .SYS_RST_IN(SYS_RST_IN),
    .rif(rif)
  );

  always_comb
  begin
    master = MODE_IN <= MODE_TMR2;
    slave = (MODE_IN == MODE_SLV_SS) || (MODE_IN == MODE_SLV);
    ss_block = (MODE_IN == MODE_SLV_SS) & SS_N_IN;
    serial_rst = !PORT_ENABLE_IN | ss_block;
    busy = state_q == ST_SHIFT;
    // Master clock stalls in sleep at every rate, freezing a master byte mid-way
    rif.run = master & busy & PORT_ENABLE_IN & !SLEEP_IN;
    rif.sel = MODE_IN[1:0];
    rif.tmr2 = TMR2_MATCH_IN;
    m_edge = rif.tick;
    // Slave clock is not gated by sleep, so bytes still arrive
    s_edge = slave & PORT_ENABLE_IN & !ss_block & (SCK_IN != sck_prev_q);
    ev = m_edge | s_edge;
    // End-of-bit sampling only applies to the master
    late_smp = master & SAMPLE_PHASE_IN;
    // Edge bit set: outputs change on odd (trailing) edges, sampled on even, or on odd when the master samples at end of bit
    change = ev & (edge_q[0] == CLOCK_EDGE_IN) & (edge_q != EDGE_LATE);
    if (late_smp)
      sample = ev & (edge_q[0] == CLOCK_EDGE_IN) & (edge_q != EDGE_ZERO);
    else
      sample = ev & (edge_q[0] != CLOCK_EDGE_IN) & (edge_q != EDGE_LATE);
    last_k = (late_smp & !CLOCK_EDGE_IN) ? EDGE_LATE : EDGE_LAST;
    last_edge = ev & (edge_q == last_k);
    rx_next = {shift_q[6:0], SDI_IN};
    rx_done = sample & (bits_q == BITS_LAST);
  end

  always_comb
  begin
    state_d = state_q;
    edge_d = edge_q;
    bits_d = bits_q;
    shift_d = shift_q;
    buf_d = buf_q;
    sdo_d = sdo_q;
    sck_d = sck_q;
    bf_d = rx_done | (bf_q & !BUF_RD_IN);
    irq_d = rx_done | (irq_q & !IRQ_CLR_IN);
    write_collision_flag_d = (BUF_WR_IN & busy) | (write_collision_flag_q & !WRITE_COLLISION_FLAG_CLR_IN);
    case (state_q)
      ST_IDLE:
      begin
        sck_d = master ? CLOCK_POLARITY_IN : sck_q;
        if (BUF_WR_IN)
        begin
          buf_d = BUF_WDATA_IN;
          shift_d = BUF_WDATA_IN;
          sdo_d = BUF_WDATA_IN[7];
        end
        if (master & PORT_ENABLE_IN & (BUF_WR_IN | !SDO_DRIVE_EN_IN))
        begin
          state_d = ST_SHIFT;
          edge_d = EDGE_ZERO;
          bits_d = BITS_ZERO;
        end
      end
      ST_SHIFT:
      begin
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
    if (ev & !(state_q == ST_IDLE & BUF_WR_IN))
    begin
      if (change)
        sdo_d = sample ? shift_q[6] : shift_q[7];
      if (sample)
      begin
        shift_d = rx_next;
        bits_d = 4'(bits_q + 4'h1);
      end
      if (rx_done)
        buf_d = rx_next;
      if (master & (edge_q != EDGE_LATE))
        sck_d = ~sck_q;
      if (last_edge)
      begin
        state_d = ST_IDLE;
        edge_d = EDGE_ZERO;
        bits_d = BITS_ZERO;
      end
      else
      begin
        state_d = ST_SHIFT;
        edge_d = 5'(edge_q + 5'h01);
      end
    end
    if (serial_rst)
    begin
      state_d = ST_IDLE;
      edge_d = EDGE_ZERO;
      bits_d = BITS_ZERO;
      sck_d = CLOCK_POLARITY_IN;
    end
    sck_oe_d = PORT_ENABLE_IN & master;
    sdo_oe_d = PORT_ENABLE_IN & SDO_DRIVE_EN_IN & !ss_block;
    wake_d = SLEEP_IN & IRQ_ENABLE_IN & irq_q;
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (SYS_RST_IN)
    begin
      state_q <= ST_IDLE;
      edge_q <= EDGE_ZERO;
      bits_q <= BITS_ZERO;
      shift_q <= BYTE_RST;
      buf_q <= BYTE_RST;
      bf_q <= 1'b0;
      irq_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      sck_q <= 1'b0;
      sck_oe_q <= 1'b0;
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
      sck_prev_q <= 1'b0;
      wake_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      edge_q <= edge_d;
      bits_q <= bits_d;
      shift_q <= shift_d;
      buf_q <= buf_d;
      bf_q <= bf_d;
      irq_q <= irq_d;
      write_collision_flag_q <= write_collision_flag_d;
      sck_q <= sck_d;
      sck_oe_q <= sck_oe_d;
      sdo_q <= sdo_d;
      sdo_oe_q <= sdo_oe_d;
      sck_prev_q <= SCK_IN;
      wake_q <= wake_d;
    end
  end

  assign BUF_RDATA_OUT = buf_q;
  assign BUFFER_FULL_OUT = bf_q;
  assign PORT_IRQ_OUT = irq_q;
  assign WRITE_COLLISION_OUT = write_collision_flag_q;
  assign BUSY_OUT = state_q == ST_SHIFT;
  assign WAKE_OUT = wake_q;
  assign SCK_OUT = sck_q;
  assign SCK_OE_OUT = sck_oe_q;
  assign SDO_OUT = sdo_q;
  assign SDO_OE_OUT = sdo_oe_q;

  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (SYS_RST_IN);

  sequence s_master_start;
    master && PORT_ENABLE_IN && !busy && BUF_WR_IN;
  endsequence
  sequence s_shifting;
    BUSY_OUT && edge_q == EDGE_ZERO;
  endsequence

  property p_byte_flags;
    rx_done |=> BUFFER_FULL_OUT && PORT_IRQ_OUT && BUF_RDATA_OUT == $past(rx_next);
  endproperty
  a_byte_flags: assert property (p_byte_flags)
    else $error("received byte did not reach buffer with flags");

  property p_collision;
    (BUF_WR_IN && busy && !rx_done) |=> WRITE_COLLISION_OUT && BUF_RDATA_OUT == $past(buf_q);
  endproperty
  a_collision: assert property (p_collision)
    else $error("write during transfer was not refused");

  property p_read_clears;
    (BUF_RD_IN && !rx_done) |=> !BUFFER_FULL_OUT;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("buffer read left full flag set");

  property p_master_start;
    s_master_start |=> s_shifting ##0 SDO_OUT == $past(BUF_WDATA_IN[7]);
  endproperty
  a_master_start: assert property (p_master_start)
    else $error("master did not start with MSB on the line");

  property p_idle_level;
    (master && !busy && !BUF_WR_IN && PORT_ENABLE_IN)[*2] |-> SCK_OUT == $past(CLOCK_POLARITY_IN);
  endproperty
  a_idle_level: assert property (p_idle_level)
    else $error("idle serial clock not at polarity level");

  property p_select_release;
    ss_block |=> !SDO_OE_OUT && edge_q == EDGE_ZERO && !BUSY_OUT;
  endproperty
  a_select_release: assert property (p_select_release)
    else $error("select high did not release output and counter");

  property p_disable_resets;
    !PORT_ENABLE_IN |=> !BUSY_OUT && !SCK_OE_OUT && !SDO_OE_OUT && bits_q == BITS_ZERO;
  endproperty
  a_disable_resets: assert property (p_disable_resets)
    else $error("disabled port kept serial state");

  property p_sleep_freeze;
    (master && busy && SLEEP_IN && PORT_ENABLE_IN) |=> $stable(edge_q) && $stable(SCK_OUT);
  endproperty
  a_sleep_freeze: assert property (p_sleep_freeze)
    else $error("master transfer moved during sleep");

  property p_slave_edge;
    (s_edge && !last_edge && !(state_q == ST_IDLE && BUF_WR_IN)) |=>
      edge_q == 5'($past(edge_q) + 5'h01);
  endproperty
  a_slave_edge: assert property (p_slave_edge)
    else $error("slave did not count an external clock edge");

  property p_rx_restart;
    (master && PORT_ENABLE_IN && !SDO_DRIVE_EN_IN && !busy) |=> BUSY_OUT;
  endproperty
  a_rx_restart: assert property (p_rx_restart)
    else $error("receive-only master did not start the next byte");

  property p_write_collision_flag_hold;
    (WRITE_COLLISION_OUT && !WRITE_COLLISION_FLAG_CLR_IN) |=> WRITE_COLLISION_OUT;
  endproperty
  a_write_collision_flag_hold: assert property (p_write_collision_flag_hold)
    else $error("collision flag dropped without a clear");
endmodule

/* File: test/spm_slave_model.sv */
// Purpose: External SPI slave device facing the port in master mode.
// Assumes: Serial clock edges are seen on the system clock.
// Notes: Outside a frame the data line shows the inverse of the MSB of tx_in.
`timescale 1ns/1ps
module spm_slave_model (
  input wire logic clk_in,
  input wire logic sel_in,
  input wire logic edge_in,
  input wire logic sck_in,
  input wire logic sdo_in,
  input wire logic [7:0] tx_in,
  output logic sdi_out,
  output logic [7:0] rx_out
);
  logic sck_q;
  logic [4:0] k_q;
  logic [7:0] sr_q;
  // A released line must not keep looking valid
  assign sdi_out = sel_in ? sr_q[7] : ~sr_q[7];
  always_ff @(posedge clk_in)
  begin
    sck_q <= sck_in;
    if (!sel_in)
    begin
      k_q <= 5'h00;
      sr_q <= tx_in;
    end
    else if (sck_in != sck_q)
    begin
      k_q <= k_q + 5'h01;
      if (k_q[0] != edge_in)
        rx_out <= {rx_out[6:0], sdo_in};
      else if (k_q != 5'h00)
        sr_q <= {sr_q[6:0], 1'b0};
    end
  end
endmodule

/* File: test/tb.sv */
// Purpose: Self-checking bench for the SPI master/slave port.
// Assumes: Inputs change on the rising edge; outputs are sampled on the falling edge.
// Notes: Slave traffic is driven by the bench in place of an external master.
`timescale 1ns/1ps
module tb;
  import spm_pkg::*;
  logic clk = 1'b0, rst = 1'b1, en = 1'b0, cpol = 1'b0, cedge = 1'b1, sample_phase = 1'b0;
  logic sdo_en = 1'b1, wr = 1'b0, rd = 1'b0, wclr = 1'b0, iclr = 1'b0, ien = 1'b0;
  logic slp = 1'b0, tmr = 1'b0, sck_i = 1'b0, sdi_i = 1'b0, ss_n = 1'b1, sel = 1'b0;
  logic [3:0] mode = MODE_DIV4;
  logic [7:0] wdata = 8'h00, ptx = 8'h00, rdata, prx, got;
  logic bf, irq, write_collision_flag, busy, wake, sck, sck_oe, serial_data_out, sdo_oe, psdi, s;
  int num_errors = 0, checks_done = 0, n;
  spm_port u_dut (.CLOCK_IN(clk), .SYS_RST_IN(rst), .PORT_ENABLE_IN(en), .MODE_IN(mode),
    .CLOCK_POLARITY_IN(cpol), .CLOCK_EDGE_IN(cedge), .SAMPLE_PHASE_IN(sample_phase),
    .SDO_DRIVE_EN_IN(sdo_en), .BUF_WR_IN(wr), .BUF_WDATA_IN(wdata), .BUF_RD_IN(rd),
    .WRITE_COLLISION_FLAG_CLR_IN(wclr), .IRQ_CLR_IN(iclr), .IRQ_ENABLE_IN(ien), .SLEEP_IN(slp),
    .TMR2_MATCH_IN(tmr), .SCK_IN(sck_i), .SDI_IN(mode[2] ? sdi_i : psdi), .SS_N_IN(ss_n),
    .BUF_RDATA_OUT(rdata), .BUFFER_FULL_OUT(bf), .PORT_IRQ_OUT(irq),
    .WRITE_COLLISION_OUT(write_collision_flag), .BUSY_OUT(busy), .WAKE_OUT(wake), .SCK_OUT(sck),
    .SCK_OE_OUT(sck_oe), .SDO_OUT(serial_data_out), .SDO_OE_OUT(sdo_oe));
  spm_slave_model u_peer (.clk_in(clk), .sel_in(sel), .edge_in(cedge), .sck_in(sck),
    .sdo_in(serial_data_out), .tx_in(ptx), .sdi_out(psdi), .rx_out(prx));
  always #25 clk = ~clk;
  task chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %0t: saw %h, expected %h", $time, g, e);
    end
  endtask
  task end_sim();
    if (num_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  task wr_byte(input logic [7:0] v);
    tick(1);
    wdata <= v;
    wr <= 1'b1;
    tick(1);
    wr <= 1'b0;
  endtask
  task wait_while(input logic lvl);
    n = 0;
    while (busy === lvl && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000)
      num_errors++;
  endtask
  task pulse_rd();
    tick(1);
    rd <= 1'b1;
    iclr <= 1'b1;
    sel <= 1'b0;
    tick(1);
    rd <= 1'b0;
    iclr <= 1'b0;
    @(negedge clk);
    chk(8'({bf, irq}), 8'h00);
  endtask
  task cfg(input logic [3:0] m, input logic p, input logic e, input logic ph);
    tick(1);
    en <= 1'b0;
    tick(1);
    mode <= m;
    cpol <= p;
    cedge <= e;
    sample_phase <= ph;
    tick(1);
    en <= 1'b1;
    tick(3);
    @(negedge clk);
  endtask
  task mxfer(input logic [7:0] tx, input logic [7:0] rx);
    tick(1);
    ptx <= rx;
    tick(1);
    sel <= 1'b1;
    wr_byte(tx);
    @(negedge clk);
    chk(8'(serial_data_out), 8'(tx[7]));
    chk(8'({busy, sck}), 8'({1'b1, cpol}));
    wait_while(1'b1);
    // The peer sees the last clock edge one cycle after the port shows it
    tick(1);
    @(negedge clk);
    chk(rdata, rx);
    chk(prx, tx);
    chk(8'({bf, irq}), 8'h03);
    pulse_rd();
  endtask
  task t_modes();
    for (int i = 0; i < 4; i++)
    begin
      cfg(MODE_DIV4, i[1], ~i[0], 1'b0);
      chk(8'({sck_oe, sck}), 8'({1'b1, i[1]}));
      mxfer(8'hA5 ^ 8'(i), 8'h3C + 8'(i));
    end
  endtask
  task t_rate();
    for (int i = 0; i < 3; i++)
    begin
      cfg(MODE_DIV4 + 4'(i), 1'b0, 1'b1, i[0]);
      mxfer(8'h81, 8'h7E);
      chk(8'(n - 8 * (DIV_FAST << (2 * i))), 8'h00);
    end
  endtask
  task t_write_collision_flag();
    cfg(MODE_DIV4, 1'b0, 1'b1, 1'b0);
    fork
      mxfer(8'h3C, 8'hC3);
      begin
        tick(8);
        wr_byte(8'hFF);
      end
    join
    chk(8'(write_collision_flag), 8'h01);
    tick(1);
    wclr <= 1'b1;
    tick(1);
    wclr <= 1'b0;
    @(negedge clk);
    chk(8'(write_collision_flag), 8'h00);
  endtask
  task t_timer();
    cfg(MODE_TMR2, 1'b1, 1'b0, 1'b0);
    fork
      mxfer(8'h5A, 8'hE7);
      begin
        tick(40);
        @(negedge clk);
        chk(8'({busy, sck}), 8'h03);
        repeat (40)
        begin
          tick(2);
          tmr <= 1'b1;
          tick(1);
          tmr <= 1'b0;
        end
      end
    join
  endtask
  task t_sleep();
    cfg(MODE_DIV16, 1'b0, 1'b1, 1'b0);
    fork
      mxfer(8'hC6, 8'h19);
      begin
        tick(30);
        slp <= 1'b1;
        tick(2);
        @(negedge clk);
        s = sck;
        tick(60);
        @(negedge clk);
        chk(8'({busy, sck}), 8'({1'b1, s}));
        tick(1);
        slp <= 1'b0;
      end
    join
  endtask
  task t_rxonly();
    tick(1);
    en <= 1'b0;
    ptx <= 8'hB4;
    sdo_en <= 1'b0;
    tick(1);
    sel <= 1'b1;
    cfg(MODE_DIV4, 1'b0, 1'b1, 1'b0);
    wait_while(1'b0);
    wait_while(1'b1);
    chk(rdata, 8'hB4);
    chk(8'(bf), 8'h01);
    tick(1);
    en <= 1'b0;
    sdo_en <= 1'b1;
    pulse_rd();
  endtask
  // Bench acts as external master, mode 0,0: data set while clock low
  task sbyte(input logic [7:0] v, input int nb);
    for (int b = 7; b > 7 - nb; b--)
    begin
      tick(1);
      sdi_i <= v[b];
      tick(3);
      @(negedge clk);
      got[b] = serial_data_out;
      tick(1);
      sck_i <= 1'b1;
      tick(4);
      sck_i <= 1'b0;
    end
    tick(4);
  endtask
  task t_slave();
    cfg(MODE_SLV_SS, 1'b0, 1'b1, 1'b0);
    sbyte(8'h11, 8);
    chk(8'({bf, sdo_oe}), 8'h00);
    tick(1);
    ss_n <= 1'b0;
    wr_byte(8'h96);
    sbyte(8'h5A, 8);
    chk(got, 8'h96);
    chk(8'(sdo_oe), 8'h01);
    chk(rdata, 8'h5A);
    chk(8'({bf, irq}), 8'h03);
    pulse_rd();
    sbyte(8'hFF, 3);
    ss_n <= 1'b1;
    tick(2);
    @(negedge clk);
    chk(8'({sdo_oe, busy}), 8'h00);
    tick(1);
    ss_n <= 1'b0;
    ien <= 1'b1;
    slp <= 1'b1;
    sbyte(8'h24, 8);
    chk(rdata, 8'h24);
    chk(8'(wake), 8'h01);
    tick(1);
    slp <= 1'b0;
    pulse_rd();
    // Plain slave mode ignores select; edge bit clear keeps select optional
    tick(1);
    ss_n <= 1'b1;
    cfg(MODE_SLV, 1'b0, 1'b0, 1'b0);
    sbyte(8'hC3, 8);
    chk(rdata, 8'hC3);
    chk(8'({bf, irq}), 8'h03);
    pulse_rd();
  endtask
  task t_reset();
    cfg(MODE_DIV4, 1'b0, 1'b1, 1'b0);
    wr_byte(8'h55);
    tick(6);
    rst <= 1'b1;
    en <= 1'b0;
    tick(1);
    rst <= 1'b0;
    @(negedge clk);
    chk(8'({busy, sck_oe, sdo_oe}), 8'h00);
  endtask
  initial
  begin
    tick(4);
    rst <= 1'b0;
    t_modes();
    t_rate();
    t_write_collision_flag();
    t_timer();
    t_sleep();
    t_rxonly();
    t_slave();
    t_reset();
    end_sim();
  end
  // About eleven times the expected run length
  initial
  begin
    #1000000;
    num_errors++;
    end_sim();
  end
endmodule
